// File: core/malp_pkg.sv
// Purpose: shared constants and types for the minor alarm priority block
// Assumes: 25 MHz system clock, synchronous active-low reset
// Notes: register offsets are byte addresses on the plain register port
package malp_pkg;
    // clock and the fixed error window, restarted every period
    localparam longint unsigned CLK_HZ = 64'd25_000_000;
    localparam longint unsigned WINDOW_S = 64'd86400;
    localparam longint unsigned WINDOW_CYC = CLK_HZ * WINDOW_S;
    localparam int WIN_W = 42;

    // register port
    localparam int AW = 8;
    localparam int DW = 32;
    localparam logic [AW-1:0] ADDR_CTRL = 8'h00;
    localparam logic [AW-1:0] ADDR_COND = 8'h04;
    localparam logic [AW-1:0] ADDR_MSG = 8'h08;
    localparam logic [AW-1:0] ADDR_ISTAT = 8'h0C;
    localparam logic [AW-1:0] ADDR_IMASK = 8'h10;
    localparam logic [AW-1:0] ADDR_ES1CNT = 8'h14;
    localparam logic [AW-1:0] ADDR_ES2CNT = 8'h18;
    localparam logic [AW-1:0] ADDR_BPVCNT = 8'h1C;

    // condition vector, index 0 is the highest display priority
    localparam int NCOND = 8;
    localparam int C_LOOP_SYNC_LOSS_ALARM = 0;
    localparam int C_LOCAL_INPUT_LOSS_ALARM = 1;
    localparam int C_REMOTE_INPUT_LOSS_ALARM = 2;
    localparam int C_LOOP1_ERRSEC_ALARM = 3;
    localparam int C_LOOP2_ERRSEC_ALARM = 4;
    localparam int C_BPV = 5;
    localparam int C_LOOP1_MARGIN_LOW = 6;
    localparam int C_LOOP2_MARGIN_LOW = 7;

    // errored-second / violation limit selection
    localparam int CNT_W = 8;
    localparam logic [1:0] ES_NONE = 2'h0;
    localparam logic [1:0] ES_17 = 2'h1;
    localparam logic [1:0] ES_170 = 2'h2;
    localparam logic [CNT_W-1:0] LIM_17 = 8'h11;
    localparam logic [CNT_W-1:0] LIM_170 = 8'hAA;
    localparam int MARGIN_W = 6;
    localparam logic [3:0] MTHR_RST = 4'h4;

    // control register layout: {margin_threshold, errored_second_limit, enable}
    typedef struct packed {
        logic [3:0] margin_threshold;
        logic [1:0] errored_second_limit;
        logic alarm_output_enable;
    } malp_cfg_t;
    localparam int CFG_W = 7;
    localparam malp_cfg_t CFG_RST = '{MTHR_RST, ES_NONE, 1'b0};

    // message shown on the display: condition code plus cut-off prefix
    typedef enum logic [3:0] {
        MALP_MSG_NONE = 4'h0,
        MALP_MSG_LOOP_SYNC_LOSS_ALARM = 4'h1,
        MALP_MSG_LOCAL_INPUT_LOSS_ALARM = 4'h2,
        MALP_MSG_REMOTE_INPUT_LOSS_ALARM = 4'h3,
        MALP_MSG_LOOP1_ERRSEC_ALARM = 4'h4,
        MALP_MSG_LOOP2_ERRSEC_ALARM = 4'h5,
        MALP_MSG_BPV = 4'h6,
        MALP_MSG_LOOP1_MARGIN_LOW = 4'h7,
        MALP_MSG_LOOP2_MARGIN_LOW = 4'h8
    } malp_msg_t;
    typedef struct packed {
        logic cutoff;
        malp_msg_t code;
    } malp_disp_t;
endpackage : malp_pkg

// File: core/malp_evcnt.sv
// Purpose: saturating event counter over a window, compared against a limit
// Assumes: win_end is a one-cycle pulse at the end of each window
// Notes: alarm is combinational from the count register
`timescale 1ns/1ns
module malp_evcnt
    import malp_pkg::*;
#(
    parameter int W = CNT_W
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // window and events
    input wire logic win_end,
    input wire logic [1:0] inc,
    // limit
    input wire logic lim_on,
    input wire logic [W-1:0] limit,
    // results
    output logic [W-1:0] count_q,
    output logic alarm
);
    logic [W:0] sum_w;
    logic [W-1:0] count_d;

    // saturate so a burst never wraps the count back under the limit
    assign sum_w = {1'b0, count_q} + {{(W-1){1'b0}}, inc};
    assign count_d = win_end ? '0 : (sum_w[W] ? '1 : sum_w[W-1:0]);
    assign alarm = lim_on && (count_q >= limit);

    // count register
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end
endmodule : malp_evcnt

// File: core/malp_top.sv
// Purpose: minor alarm output, red status flash and one-message alarm display
// Assumes: condition inputs and button pulse synchronous to clock
// Notes: errored-second windows restart together every window period
//
// Summary of operation
// R1: minor alarm output asserts while any listed condition is active.
// R2: with several conditions active, only one message is shown.
// R3: priority: sync loss, local loss, remote loss, ES1, ES2, violations, margin.
// R4: each loop alarms when its window errored-second count reaches the limit.
// R5: combined local and remote violation count alarms against the same limit.
// R6: each loop alarms while its margin is below the margin threshold.
// R7: output held while the condition lasts and released once it clears.
// R8: red status flash throughout any minor alarm condition.
// R9: select press during an alarm cuts off the alarm output.
// R10: after cut-off the prefix shows cut-off, the condition code stays.
// R11: disabling the alarm output also clears any cut-off.
// R12: disabled output never asserts; flash and message still work.
// R13: a new condition after cut-off ends cut-off and re-asserts output.
// R14: error limit is 17, 170 or none; none is the reset value.
// R15: margin threshold 0 to 15 dB, reset value 4 dB.
// R16: alarm output option resets disabled; toggling gates the output.
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ns
module malp_top
    import malp_pkg::*;
#(
    parameter longint unsigned WINDOW_CYCLES = WINDOW_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // line conditions
    input wire logic loop1_sync_loss,
    input wire logic loop2_sync_loss,
    input wire logic local_input_loss,
    input wire logic remote_input_loss,
    input wire logic loop1_errsec,
    input wire logic loop2_errsec,
    input wire logic bpv_local,
    input wire logic bpv_remote,
    input wire logic [MARGIN_W-1:0] loop1_margin,
    input wire logic [MARGIN_W-1:0] loop2_margin,
    // front panel
    input wire logic select_press,
    output logic led_red_flash,
    output malp_disp_t disp_q,
    // alarm bus
    output logic minor_alarm_out,
    output logic irq,
    // register port
    input wire logic [AW-1:0] reg_addr,
    input wire logic [DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DW-1:0] reg_rdata_q
);
    malp_cfg_t cfg_q;
    logic [NCOND-1:0] cond_w;
    logic [NCOND-1:0] cond_q;
    logic [NCOND-1:0] rise_w;
    logic [NCOND-1:0] istat_q;
    logic [NCOND-1:0] imask_q;
    logic [WIN_W-1:0] win_q;
    logic win_end;
    logic lim_on;
    logic [CNT_W-1:0] limit_w;
    logic [CNT_W-1:0] es1_cnt;
    logic [CNT_W-1:0] es2_cnt;
    logic [CNT_W-1:0] bpv_cnt;
    logic es1_alarm;
    logic es2_alarm;
    logic bpv_alarm;
    logic any_w;
    logic new_w;
    logic cutoff_q;
    logic cutoff_d;
    logic alarm_d;
    logic flash_q;
    malp_msg_t msg_w;
    logic wr_ctrl;
    logic wr_istat;
    logic wr_imask;
    logic [DW-1:0] rd_mux;

    // window timer; one shared window keeps three counters in step
    assign win_end = (win_q == WIN_W'(WINDOW_CYCLES - 64'd1));
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            win_q <= '0;
        end else begin
            win_q <= win_end ? '0 : win_q + WIN_W'(1);
        end
    end

    // limit decode; a reserved selection code behaves as none
    assign lim_on = (cfg_q.errored_second_limit == ES_17) // R14
        || (cfg_q.errored_second_limit == ES_170);
    assign limit_w = (cfg_q.errored_second_limit == ES_170) ? LIM_170 : LIM_17; // R14

    // per-loop errored seconds and combined violation counts
    malp_evcnt #(.W(CNT_W)) u_es1 ( // R4
        .clock(clock),
        .rst_b(rst_b),
        .win_end(win_end),
        .inc({1'b0, loop1_errsec}),
        .lim_on(lim_on),
        .limit(limit_w),
        .count_q(es1_cnt),
        .alarm(es1_alarm)
    );
    malp_evcnt #(.W(CNT_W)) u_es2 ( // R4
        .clock(clock),
        .rst_b(rst_b),
        .win_end(win_end),
        .inc({1'b0, loop2_errsec}),
        .lim_on(lim_on),
        .limit(limit_w),
        .count_q(es2_cnt),
        .alarm(es2_alarm)
    );
    malp_evcnt #(.W(CNT_W)) u_bpv ( // R5
        .clock(clock),
        .rst_b(rst_b),
        .win_end(win_end),
        .inc({1'b0, bpv_local} + {1'b0, bpv_remote}),
        .lim_on(lim_on),
        .limit(limit_w),
        .count_q(bpv_cnt),
        .alarm(bpv_alarm)
    );

    // condition vector in display priority order
    assign cond_w[C_LOOP_SYNC_LOSS_ALARM] = loop1_sync_loss || loop2_sync_loss;
    assign cond_w[C_LOCAL_INPUT_LOSS_ALARM] = local_input_loss;
    assign cond_w[C_REMOTE_INPUT_LOSS_ALARM] = remote_input_loss;
    assign cond_w[C_LOOP1_ERRSEC_ALARM] = es1_alarm;
    assign cond_w[C_LOOP2_ERRSEC_ALARM] = es2_alarm;
    assign cond_w[C_BPV] = bpv_alarm;
    assign cond_w[C_LOOP1_MARGIN_LOW] = loop1_margin < {2'h0, cfg_q.margin_threshold}; // R6 R15
    assign cond_w[C_LOOP2_MARGIN_LOW] = loop2_margin < {2'h0, cfg_q.margin_threshold}; // R6 R15
    assign any_w = |cond_w;
    assign rise_w = cond_w & ~cond_q;
    assign new_w = |rise_w;

    // highest priority active condition wins the single message
    always_comb begin
        msg_w = MALP_MSG_NONE;
        for (int i = NCOND - 1; i >= 0; i--) begin
            if (cond_w[i]) begin
                msg_w = malp_msg_t'(4'(i + 1)); // R2 R3
            end
        end
    end

    // cut-off: a press during an alarm wins over a same-cycle new alarm
    always_comb begin
        if (!cfg_q.alarm_output_enable) begin
            cutoff_d = 1'b0; // R11
        end else if (select_press && any_w) begin
            cutoff_d = 1'b1; // R9
        end else if (new_w || !any_w) begin
            cutoff_d = 1'b0; // R13
        end else begin
            cutoff_d = cutoff_q;
        end
    end
    assign alarm_d = any_w && cfg_q.alarm_output_enable && !cutoff_d; // R1 R7 R12 R16

    // alarm state, output and display registers
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cond_q <= '0;
            cutoff_q <= 1'b0;
            minor_alarm_out <= 1'b0;
            flash_q <= 1'b0;
            disp_q <= '{1'b0, MALP_MSG_NONE};
        end else begin
            cond_q <= cond_w;
            cutoff_q <= cutoff_d;
            minor_alarm_out <= alarm_d; // R7
            flash_q <= any_w; // R8
            disp_q <= '{cutoff_d, msg_w}; // R10
        end
    end
    assign led_red_flash = flash_q; // R8

    // register decode
    assign wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
    assign wr_istat = reg_wr && (reg_addr == ADDR_ISTAT);
    assign wr_imask = reg_wr && (reg_addr == ADDR_IMASK);
    assign rd_mux = (reg_addr == ADDR_CTRL) ? DW'(cfg_q)
        : (reg_addr == ADDR_COND) ? DW'({cutoff_q, cond_w})
        : (reg_addr == ADDR_MSG) ? DW'(disp_q)
        : (reg_addr == ADDR_ISTAT) ? DW'(istat_q)
        : (reg_addr == ADDR_IMASK) ? DW'(imask_q)
        : (reg_addr == ADDR_ES1CNT) ? DW'(es1_cnt)
        : (reg_addr == ADDR_ES2CNT) ? DW'(es2_cnt)
        : (reg_addr == ADDR_BPVCNT) ? DW'(bpv_cnt)
        : '0;

    // configuration; reset leaves the output disabled and no error limit
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cfg_q <= CFG_RST; // R14 R15 R16
            imask_q <= '0;
        end else begin
            if (wr_ctrl) begin
                cfg_q <= malp_cfg_t'(reg_wdata[CFG_W-1:0]);
            end
            if (wr_imask) begin
                imask_q <= reg_wdata[NCOND-1:0];
            end
        end
    end

    // sticky interrupt status; a rising condition beats a write-one clear
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            istat_q <= '0;
        end else begin
            istat_q <= rise_w | (istat_q & ~(wr_istat ? reg_wdata[NCOND-1:0] : '0));
        end
    end
    assign irq = |(istat_q & imask_q);

    // read data stand for one cycle only
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            reg_rdata_q <= '0;
        end else begin
            reg_rdata_q <= reg_rd ? rd_mux : '0;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    property p_alarm_on;
        (any_w && cfg_q.alarm_output_enable && !cutoff_q && !select_press) |=> minor_alarm_out;
    endproperty
    a_alarm_on: assert property (p_alarm_on) else $error("alarm output missing"); // R1

    property p_release;
        !any_w |=> !minor_alarm_out;
    endproperty
    a_release: assert property (p_release) else $error("alarm output not released"); // R7

    property p_disabled;
        !cfg_q.alarm_output_enable |=> !minor_alarm_out ##0 (flash_q == $past(any_w));
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled output asserted"); // R12

    property p_top_prio;
        cond_w[C_LOOP_SYNC_LOSS_ALARM] |=> (disp_q.code == MALP_MSG_LOOP_SYNC_LOSS_ALARM);
    endproperty
    a_top_prio: assert property (p_top_prio) else $error("sync loss not shown first"); // R3

    property p_prio_order;
        (cond_w[C_LOOP1_ERRSEC_ALARM] && !cond_w[C_LOOP_SYNC_LOSS_ALARM] && !cond_w[C_LOCAL_INPUT_LOSS_ALARM] && !cond_w[C_REMOTE_INPUT_LOSS_ALARM])
            |=> (disp_q.code == MALP_MSG_LOOP1_ERRSEC_ALARM);
    endproperty
    a_prio_order: assert property (p_prio_order) else $error("wrong message priority"); // R2

    property p_cutoff;
        (select_press && any_w && cfg_q.alarm_output_enable) |=> !minor_alarm_out && disp_q.cutoff;
    endproperty
    a_cutoff: assert property (p_cutoff) else $error("cut-off not taken"); // R9

    property p_disable_clears;
        (wr_ctrl && !reg_wdata[0]) |=> ##1 !cutoff_q;
    endproperty
    a_disable_clears: assert property (p_disable_clears) else $error("cut-off survived"); // R11

    property p_new_alarm;
        (cutoff_q && new_w && !select_press && cfg_q.alarm_output_enable) |=> minor_alarm_out;
    endproperty
    a_new_alarm: assert property (p_new_alarm) else $error("new alarm not raised"); // R13

    property p_none_limit;
        (cfg_q.errored_second_limit == ES_NONE) |-> !cond_w[C_LOOP1_ERRSEC_ALARM] && !cond_w[C_LOOP2_ERRSEC_ALARM];
    endproperty
    a_none_limit: assert property (p_none_limit) else $error("alarm with no limit"); // R14

    property p_irq_set_wins;
        (rise_w[C_LOOP_SYNC_LOSS_ALARM] && wr_istat && reg_wdata[C_LOOP_SYNC_LOSS_ALARM]) |=> istat_q[C_LOOP_SYNC_LOSS_ALARM];
    endproperty
    a_irq_set_wins: assert property (p_irq_set_wins) else $error("event lost on clear");

    property p_flash;
        any_w |=> led_red_flash;
    endproperty
    a_flash: assert property (p_flash) else $error("red flash missing"); // R8

    property p_idle_msg;
        !any_w |=> (disp_q.code == MALP_MSG_NONE) && !disp_q.cutoff;
    endproperty
    a_idle_msg: assert property (p_idle_msg) else $error("message left after clear"); // R10

    property p_window_clear;
        win_end |=> (es1_cnt == '0) && (es2_cnt == '0) && (bpv_cnt == '0);
    endproperty
    a_window_clear: assert property (p_window_clear) else $error("count kept past window"); // R4

    property p_mal_order;
        (cond_w[C_LOOP1_MARGIN_LOW] && cond_w[C_LOOP2_MARGIN_LOW]) |=> (disp_q.code != MALP_MSG_LOOP2_MARGIN_LOW);
    endproperty
    a_mal_order: assert property (p_mal_order) else $error("loop2 margin shown first"); // R3
endmodule : malp_top

// File: verification/malp_panel.sv
// Purpose: front-panel user model that presses the select button on request
// Assumes: one request pulse from the bench gives one select pulse a cycle later
// Notes: presses only when told, so a press outside an alarm is a bench choice
`timescale 1ns/1ns
module malp_panel (
    // clock
    input wire logic clock,
    // request from the bench
    input wire logic press_req,
    // front panel button
    output logic select_press
);
    // button pulse, one clock long, launched just after an edge
    initial select_press = 1'b0;
    always @(posedge clock) begin
        select_press <= press_req;
    end
endmodule : malp_panel

// File: verification/testbench.sv
// Purpose: self-checking bench for the minor alarm priority block
// Assumes: short error window so counter alarms fit in one run
// Notes: register reads are checked from a queue by a separate watcher
`timescale 1ns/1ns
module testbench;
    import malp_pkg::*;
    localparam longint unsigned WIN = 512;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic loop1_sync_loss = 1'b0, loop2_sync_loss = 1'b0;
    logic local_input_loss = 1'b0, remote_input_loss = 1'b0;
    logic loop1_errsec = 1'b0, loop2_errsec = 1'b0, bpv_local = 1'b0, bpv_remote = 1'b0;
    logic [MARGIN_W-1:0] loop1_margin = 6'h14, loop2_margin = 6'h14;
    logic select_press, press_req = 1'b0, led_red_flash, minor_alarm_out, irq;
    malp_disp_t disp_q;
    logic [AW-1:0] reg_addr = 8'h00;
    logic [DW-1:0] reg_wdata = 32'h0, reg_rdata_q;
    logic reg_wr = 1'b0, reg_rd = 1'b0, rd_seen = 1'b0, alt = 1'b0;
    logic [DW-1:0] exp_q[$];
    logic [5:0] t;
    logic [3:0] codes [5] = '{4'h1, 4'h2, 4'h3, 4'h7, 4'h8};
    int bad_count = 0, comparisons = 0, cyc = 0, seed = 10;

    always #20 clock = ~clock;

    malp_top #(.WINDOW_CYCLES(WIN)) dut (.clock(clock), .rst_b(rst_b),
        .loop1_sync_loss(loop1_sync_loss), .loop2_sync_loss(loop2_sync_loss),
        .local_input_loss(local_input_loss), .remote_input_loss(remote_input_loss),
        .loop1_errsec(loop1_errsec), .loop2_errsec(loop2_errsec), .bpv_local(bpv_local),
        .bpv_remote(bpv_remote), .loop1_margin(loop1_margin), .loop2_margin(loop2_margin),
        .select_press(select_press), .led_red_flash(led_red_flash), .disp_q(disp_q),
        .minor_alarm_out(minor_alarm_out), .irq(irq), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));
    malp_panel panel (.clock(clock), .press_req(press_req), .select_press(select_press));

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : tally_and_finish

    task automatic check(input string what, input logic [DW-1:0] seen, input logic [DW-1:0] e);
        comparisons++;
        if (seen !== e) begin
            bad_count++;
            $display("Error %s expected %0h seen %0h", what, e, seen);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : step

    // read data stand only in the cycle after the strobe, so look there
    always @(posedge clock) rd_seen <= reg_rd;
    always @(negedge clock) begin
        if (rd_seen) check("reg_rdata_q", reg_rdata_q, exp_q.pop_front());
    end

    // a hang is cut short well past the expected run length
    always @(posedge clock) begin
        cyc <= rst_b ? cyc + 1 : 0;
        if (cyc > 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clock);
        reg_rd <= 1'b0;
    endtask : rd

    // levels: {loop2 sync, loop2 margin, loop1 margin, remote, local, loop1 sync}
    task automatic set_lv(input logic [5:0] v);
        @(posedge clock);
        loop1_sync_loss <= v[0];
        local_input_loss <= v[1];
        remote_input_loss <= v[2];
        loop1_margin <= v[3] ? 6'h00 : 6'h14;
        loop2_margin <= v[4] ? 6'h00 : 6'h14;
        loop2_sync_loss <= v[5];
    endtask : set_lv

    task automatic chk_out(input logic o, input logic [4:0] d, input logic l);
        step(2);
        check("minor_alarm_out", {31'h0, minor_alarm_out}, {31'h0, o});
        check("disp_q", {27'h0, disp_q}, {27'h0, d});
        check("led_red_flash", {31'h0, led_red_flash}, {31'h0, l});
    endtask : chk_out

    task automatic press;
        @(posedge clock);
        press_req <= 1'b1;
        @(posedge clock);
        press_req <= 1'b0;
        @(posedge clock);
    endtask : press

    task automatic pulse(input int sel);
        @(posedge clock);
        alt <= ~alt;
        loop1_errsec <= (sel == 0);
        loop2_errsec <= (sel == 1);
        bpv_local <= (sel == 2) && alt;
        bpv_remote <= (sel == 2) && !alt;
        @(posedge clock);
        {loop1_errsec, loop2_errsec, bpv_local, bpv_remote} <= 4'h0;
    endtask : pulse

    // counts start fresh at a window start so the run never straddles a window end
    task automatic es_run(input int sel, input int n, input logic [3:0] code);
        while (cyc % WIN != 4) @(posedge clock);
        repeat (n - 1) pulse(sel);
        chk_out(1'b0, 5'h00, 1'b0);
        pulse(sel);
        step(1);
        chk_out(code != 4'h0, {1'b0, code}, code != 4'h0);
        if (code != 4'h0) rd(ADDR_ES1CNT + 8'(4 * sel), DW'(n));
    endtask : es_run

    initial begin
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        chk_out(1'b0, 5'h00, 1'b0);
        rd(ADDR_CTRL, 32'h20);
        $display("test reset values done");
        wr(ADDR_CTRL, 32'h21);
        for (int j = 0; j < 5; j++) begin
            // keep loop2 sync out of the shifted mask so each step drops one level
            set_lv(6'h1F & (6'h1F << j));
            chk_out(1'b1, {1'b0, codes[j]}, 1'b1);
            rd(ADDR_MSG, {28'h0, codes[j]});
        end
        set_lv(6'h00);
        chk_out(1'b0, 5'h00, 1'b0);
        $display("test priority done");
        set_lv(6'h02);
        chk_out(1'b1, 5'h02, 1'b1);
        press;
        chk_out(1'b0, 5'h12, 1'b1);
        set_lv(6'h22);
        chk_out(1'b1, 5'h01, 1'b1);
        press;
        chk_out(1'b0, 5'h11, 1'b1);
        wr(ADDR_CTRL, 32'h20);
        chk_out(1'b0, 5'h01, 1'b1);
        wr(ADDR_CTRL, 32'h21);
        chk_out(1'b1, 5'h01, 1'b1);
        set_lv(6'h00);
        $display("test cut-off done");
        for (int k = 0; k < 3; k++) begin
            t = (k == 0) ? 6'h00 : (k == 1) ? 6'h0F : 6'($random(seed) & 15);
            wr(ADDR_CTRL, {25'h0, t[3:0], 3'b001});
            @(posedge clock);
            loop1_margin <= t;
            loop2_margin <= t + 6'($random(seed) & 15);
            chk_out(1'b0, 5'h00, 1'b0);
            if (t != 6'h00) begin
                @(posedge clock);
                loop1_margin <= t - 6'h01;
                chk_out(1'b1, 5'h07, 1'b1);
            end
        end
        set_lv(6'h00);
        wr(ADDR_CTRL, 32'h21);
        $display("test margin done");
        es_run(0, 17, 4'h0);
        wr(ADDR_CTRL, 32'h23);
        es_run(0, 17, 4'h4);
        es_run(2, 17, 4'h6);
        wr(ADDR_CTRL, 32'h25);
        es_run(1, 170, 4'h5);
        $display("test error counts done");
        wr(ADDR_IMASK, 32'h0);
        wr(ADDR_ISTAT, 32'hFF);
        set_lv(6'h02);
        step(2);
        check("irq", {31'h0, irq}, 32'h0);
        rd(ADDR_ISTAT, 32'h02);
        wr(ADDR_IMASK, 32'h02);
        step(1);
        check("irq", {31'h0, irq}, 32'h1);
        wr(ADDR_ISTAT, 32'h02);
        step(1);
        check("irq", {31'h0, irq}, 32'h0);
        // loop2 errored seconds still stand at the limit until the window ends
        rd(ADDR_COND, 32'h12);
        wr(ADDR_CTRL, 32'h27);
        rd(ADDR_COND, 32'h02);
        wr(8'h40, 32'hFF);
        rd(8'h40, 32'h0);
        rd(ADDR_CTRL, 32'h27);
        step(3);
        $display("test interrupt and map done");
        tally_and_finish();
    end
endmodule : testbench
